// ===== hdl/gci_regs.svh
`ifndef GCI_REGS_SVH
`define GCI_REGS_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define GCI_FRAME_BITS 16
`define GCI_CNT_W 5
`define GCI_OP_MSB 15
`define GCI_OP_LSB 12
`define GCI_ARG_MSB 11

// ----------------------------------------------------------------
// Command opcodes and keys
// ----------------------------------------------------------------
`define GCI_OP_DEADTIME 4'h1
`define GCI_OP_CLEAR 4'h3
`define GCI_OP_SAFE 4'h6
`define GCI_SAFE_KEY 12'ha5c

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define GCI_DT_W 8
`define GCI_SAMPLE_W 10
`define GCI_DT_RESET 8'h10
`define GCI_PIN_SYNC_RST 12'h021c

`endif

// ===== hdl/gci_pkg.sv
`include "gci_regs.svh"

// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package gci_pkg;

	// Conduction state of one half bridge
	typedef enum logic [2:0] {
		PH_OFF,
		PH_HIGH,
		PH_LOW,
		PH_BOTH,
		PH_DEAD
	} gci_phase_state_t;

	// Opcode field of a serial frame
	typedef logic [`GCI_OP_MSB-`GCI_OP_LSB:0] gci_op_t;

endpackage

// ===== hdl/gci_phase_if.sv
`timescale 1ns/1ps
`include "gci_regs.svh"

// ----------------------------------------------------------------
// Control path from the front end to one phase driver
// ----------------------------------------------------------------
interface gci_phase_if #(
	parameter int DT_W = `GCI_DT_W
);
	logic hi_req;
	logic lo_req;
	logic overlap_en;
	logic [DT_W-1:0] dead_time;
	logic hi_gate;
	logic lo_gate;

	// Driver side of the phase
	modport drv (
		input hi_req,
		input lo_req,
		input overlap_en,
		input dead_time,
		output hi_gate,
		output lo_gate
	);

	// Front end side of the phase
	modport ctl (
		output hi_req,
		output lo_req,
		output overlap_en,
		output dead_time,
		input hi_gate,
		input lo_gate
	);
endinterface

// ===== hdl/gci_phase_drv.sv
`timescale 1ns/1ps
`include "gci_regs.svh"

// ----------------------------------------------------------------
// One half bridge: interlock and dead time
// ----------------------------------------------------------------
module gci_phase_drv
	import gci_pkg::*;
#(
	parameter int DT_W = `GCI_DT_W
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	gci_phase_if.drv ph
);

	gci_phase_state_t state_reg;
	gci_phase_state_t state_next;
	logic [DT_W-1:0] cnt_reg;
	logic [DT_W-1:0] cnt_next;
	logic hi_reg;
	logic hi_next;
	logic lo_reg;
	logic lo_next;
	logic want_hi;
	logic want_lo;
	logic want_both;

	// Next state; leaving PH_HIGH, PH_LOW or PH_BOTH for anything but PH_BOTH passes through the dead phase
	always_comb begin
		want_both = ph.hi_req & ph.lo_req & ph.overlap_en;
		want_hi = ph.hi_req & ~ph.lo_req;
		want_lo = ph.lo_req & ~ph.hi_req;
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			PH_OFF: begin
				if (want_both) begin
					state_next = PH_BOTH;
				end else if (want_hi) begin
					state_next = PH_HIGH;
				end else if (want_lo) begin
					state_next = PH_LOW;
				end
			end
			PH_HIGH: begin
				if (want_both) begin
					state_next = PH_BOTH;
				end else if (!want_hi) begin
					state_next = PH_DEAD;
					cnt_next = ph.dead_time;
				end
			end
			PH_LOW: begin
				if (want_both) begin
					state_next = PH_BOTH;
				end else if (!want_lo) begin
					state_next = PH_DEAD;
					cnt_next = ph.dead_time;
				end
			end
			PH_BOTH: begin
				if (!want_both) begin
					state_next = PH_DEAD;
					cnt_next = ph.dead_time;
				end
			end
			PH_DEAD: begin
				if (cnt_reg == '0) begin
					state_next = PH_OFF;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			default: begin
				state_next = PH_OFF;
			end
		endcase
		hi_next = (state_next == PH_HIGH) || (state_next == PH_BOTH);
		lo_next = (state_next == PH_LOW) || (state_next == PH_BOTH);
	end

	// Gates come straight from flops, so no decode glitch reaches a FET
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= PH_OFF;
			cnt_reg <= '0;
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			hi_reg <= hi_next;
			lo_reg <= lo_next;
		end
	end

	assign ph.hi_gate = hi_reg;
	assign ph.lo_gate = lo_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_hi_needs_cmd;
		ph.hi_gate |-> $past(ph.hi_req);
	endproperty
	a_hi_needs_cmd: assert property (p_hi_needs_cmd) else $error("high gate without command");

	property p_lo_needs_cmd;
		ph.lo_gate |-> $past(ph.lo_req);
	endproperty
	a_lo_needs_cmd: assert property (p_lo_needs_cmd) else $error("low gate without command");

	property p_gap_after_high;
		$fell(ph.hi_gate) |-> (!ph.lo_gate)[*2];
	endproperty
	a_gap_after_high: assert property (p_gap_after_high) else $error("no dead gap");

	property p_overlap_safe;
		(ph.hi_gate && ph.lo_gate) |-> $past(ph.overlap_en);
	endproperty
	a_overlap_safe: assert property (p_overlap_safe) else $error("overlap not armed");

endmodule

// ===== hdl/gci_top.sv
`timescale 1ns/1ps
`include "gci_regs.svh"

// Notes on behaviour
// - Gates may turn on only while both enable inputs are high.
// - A low high-side command turns that phase's high-side gate on.
// - A high low-side command turns that phase's low-side gate on.
// - Midpoint flag low while source is below half the load supply.
// - Serial input sampled on falling clock edge, most significant bit first.
// - Serial output floats until select goes low; drives only while selected.
// - Active-low select frames each command; no serial activity without it.
// - Asynchronous reset, enables, interrupt output beside the serial port.
// - Dead time between high and low conduction is set over serial port.
// - Both gates of a phase together only after the safe command.
// - Overcurrent flag output follows the overcurrent comparator.
module gci_top
	import gci_pkg::*;
#(
	parameter int SAMPLE_W = `GCI_SAMPLE_W,
	parameter int DT_W = `GCI_DT_W
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic gate_enable_a_in,
	input wire logic gate_enable_b_in,
	input wire logic ph_a_high_cmd_n_in,
	input wire logic ph_b_high_cmd_n_in,
	input wire logic ph_c_high_cmd_n_in,
	input wire logic ph_a_low_cmd_in,
	input wire logic ph_b_low_cmd_in,
	input wire logic ph_c_low_cmd_in,
	input wire logic [SAMPLE_W-1:0] high_source_a_in,
	input wire logic [SAMPLE_W-1:0] high_source_b_in,
	input wire logic [SAMPLE_W-1:0] high_source_c_in,
	input wire logic [SAMPLE_W-1:0] load_supply_level_in,
	input wire logic overcurrent_cmp_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	output logic [2:0] high_gate_out,
	output logic [2:0] low_gate_out,
	output logic midpoint_flag_a_out,
	output logic midpoint_flag_b_out,
	output logic midpoint_flag_c_out,
	output logic overcurrent_flag_out,
	output logic irq_out,
	output logic so_out,
	output logic so_oe_n_out
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [11:0] pin_raw;
	logic [11:0] pin_meta_reg;
	logic [11:0] pin_sync_reg;
	logic [3:0][SAMPLE_W-1:0] lvl_raw;
	logic [3:0][SAMPLE_W-1:0] lvl_meta_reg;
	logic [3:0][SAMPLE_W-1:0] lvl_sync_reg;

	// Packs the single-bit pins; select and high commands rest high
	assign pin_raw = {overcurrent_cmp_in, si_in, cs_n_in, sclk_in,
		ph_c_low_cmd_in, ph_b_low_cmd_in, ph_a_low_cmd_in,
		ph_c_high_cmd_n_in, ph_b_high_cmd_n_in, ph_a_high_cmd_n_in,
		gate_enable_b_in, gate_enable_a_in};
	assign lvl_raw = {load_supply_level_in, high_source_c_in,
		high_source_b_in, high_source_a_in};

	// Two stages before use; the level words move slowly, so a torn
	// sample only shifts the flag decision by one clock
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta_reg <= `GCI_PIN_SYNC_RST;
			pin_sync_reg <= `GCI_PIN_SYNC_RST;
			lvl_meta_reg <= '0;
			lvl_sync_reg <= '0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			lvl_meta_reg <= lvl_raw;
			lvl_sync_reg <= lvl_meta_reg;
		end
	end

	// Named views of the synchronised pins
	logic en_ok;
	logic [2:0] hi_n_s;
	logic [2:0] lo_s;
	logic sclk_s;
	logic cs_n_s;
	logic si_s;
	logic oc_s;

	assign en_ok = pin_sync_reg[0] & pin_sync_reg[1];
	assign hi_n_s = pin_sync_reg[4:2];
	assign lo_s = pin_sync_reg[7:5];
	assign sclk_s = pin_sync_reg[8];
	assign cs_n_s = pin_sync_reg[9];
	assign si_s = pin_sync_reg[10];
	assign oc_s = pin_sync_reg[11];

	// ----------------------------------------------------------------
	// Midpoint and overcurrent status
	// ----------------------------------------------------------------
	logic [2:0] mid_reg;
	logic [2:0] mid_next;
	logic oc_reg;
	logic oc_next;

	// Flag high once twice the source reaches the supply level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			mid_next[i] = {lvl_sync_reg[i], 1'b0} >= {1'b0, lvl_sync_reg[3]};
		end
		oc_next = oc_s;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mid_reg <= 3'h0;
			oc_reg <= 1'b0;
		end else begin
			mid_reg <= mid_next;
			oc_reg <= oc_next;
		end
	end

	assign midpoint_flag_a_out = mid_reg[0];
	assign midpoint_flag_b_out = mid_reg[1];
	assign midpoint_flag_c_out = mid_reg[2];
	assign overcurrent_flag_out = oc_reg;

	// ----------------------------------------------------------------
	// Serial setup port
	// ----------------------------------------------------------------
	logic sclk_d_reg;
	logic cs_d_reg;
	logic [`GCI_FRAME_BITS-1:0] rx_reg;
	logic [`GCI_FRAME_BITS-1:0] rx_next;
	logic [`GCI_FRAME_BITS-1:0] tx_reg;
	logic [`GCI_FRAME_BITS-1:0] tx_next;
	logic [`GCI_CNT_W-1:0] bit_cnt_reg;
	logic [`GCI_CNT_W-1:0] bit_cnt_next;
	logic [DT_W-1:0] dead_reg;
	logic [DT_W-1:0] dead_next;
	logic overlap_en_reg;
	logic overlap_en_next;
	logic frame_err_reg;
	logic frame_err_next;
	logic oc_evt_reg;
	logic oc_evt_next;
	logic irq_reg;
	logic irq_next;
	logic so_reg;
	logic so_next;
	logic so_oe_n_reg;
	logic so_oe_n_next;
	logic sclk_fall;
	logic sclk_rise;
	logic cs_fall;
	logic cs_rise;
	logic frame_ok;
	logic frame_bad;
	gci_op_t op;
	logic [`GCI_FRAME_BITS-1:0] status_word;

	// Edges of the sampled link clock and select
	assign sclk_fall = sclk_d_reg & ~sclk_s;
	assign sclk_rise = ~sclk_d_reg & sclk_s;
	assign cs_fall = cs_d_reg & ~cs_n_s;
	assign cs_rise = ~cs_d_reg & cs_n_s;
	// Only a frame of exactly the right length is executed
	assign frame_ok = cs_rise && (bit_cnt_reg == `GCI_CNT_W'(`GCI_FRAME_BITS));
	assign frame_bad = cs_rise && (bit_cnt_reg != `GCI_CNT_W'(`GCI_FRAME_BITS));
	assign op = rx_reg[`GCI_OP_MSB:`GCI_OP_LSB];
	// Reply loaded at select; the cast drops the top flags if the dead time is wider than 8 bits
	assign status_word = `GCI_FRAME_BITS'({overlap_en_reg, frame_err_reg, oc_evt_reg,
		oc_reg, mid_reg, 1'b0, dead_reg});

	// Shift, count and command decode
	always_comb begin
		rx_next = rx_reg;
		tx_next = tx_reg;
		bit_cnt_next = bit_cnt_reg;
		dead_next = dead_reg;
		overlap_en_next = overlap_en_reg;
		frame_err_next = frame_err_reg;
		oc_evt_next = oc_evt_reg;
		if (cs_fall) begin
			bit_cnt_next = '0;
			tx_next = status_word;
		end else if (!cs_n_s && sclk_fall) begin
			rx_next = {rx_reg[`GCI_FRAME_BITS-2:0], si_s};
			if (bit_cnt_reg != `GCI_CNT_W'(`GCI_FRAME_BITS + 1)) begin
				bit_cnt_next = bit_cnt_reg + 1'b1;
			end
		end else if (!cs_n_s && sclk_rise && bit_cnt_reg != '0) begin
			// First rising edge keeps the MSB for the first sample
			tx_next = {tx_reg[`GCI_FRAME_BITS-2:0], 1'b0};
		end
		if (frame_ok) begin
			case (op)
				`GCI_OP_DEADTIME: begin
					dead_next = rx_reg[DT_W-1:0];
				end
				`GCI_OP_SAFE: begin
					// Any other key disarms overlap again
					overlap_en_next = rx_reg[`GCI_ARG_MSB:0] == `GCI_SAFE_KEY;
				end
				`GCI_OP_CLEAR: begin
					frame_err_next = 1'b0;
					oc_evt_next = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// New events beat a clear in the same cycle
		if (frame_bad) begin
			frame_err_next = 1'b1;
		end
		if (oc_s && !oc_reg) begin
			oc_evt_next = 1'b1;
		end
		irq_next = frame_err_next | oc_evt_next;
		so_next = cs_n_s ? 1'b0 : tx_next[`GCI_FRAME_BITS-1];
		so_oe_n_next = cs_n_s;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
			rx_reg <= '0;
			tx_reg <= '0;
			bit_cnt_reg <= '0;
			dead_reg <= `GCI_DT_RESET;
			overlap_en_reg <= 1'b0;
			frame_err_reg <= 1'b0;
			oc_evt_reg <= 1'b0;
			irq_reg <= 1'b0;
			so_reg <= 1'b0;
			so_oe_n_reg <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			cs_d_reg <= cs_n_s;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			bit_cnt_reg <= bit_cnt_next;
			dead_reg <= dead_next;
			overlap_en_reg <= overlap_en_next;
			frame_err_reg <= frame_err_next;
			oc_evt_reg <= oc_evt_next;
			irq_reg <= irq_next;
			so_reg <= so_next;
			so_oe_n_reg <= so_oe_n_next;
		end
	end

	assign irq_out = irq_reg;
	assign so_out = so_reg;
	assign so_oe_n_out = so_oe_n_reg;

	// ----------------------------------------------------------------
	// Phase drivers
	// ----------------------------------------------------------------
	gci_phase_if #(.DT_W(DT_W)) ph_if[3] ();

	for (genvar i = 0; i < 3; i++) begin : g_phase
		// Enables gate both sides before any interlock sees them
		assign ph_if[i].hi_req = en_ok & ~hi_n_s[i];
		assign ph_if[i].lo_req = en_ok & lo_s[i];
		assign ph_if[i].overlap_en = overlap_en_reg;
		assign ph_if[i].dead_time = dead_reg;
		gci_phase_drv #(.DT_W(DT_W)) u_drv (
			.ref_clk_in(ref_clk_in),
			.rst_n_in(rst_n_in),
			.ph(ph_if[i])
		);
		assign high_gate_out[i] = ph_if[i].hi_gate;
		assign low_gate_out[i] = ph_if[i].lo_gate;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_enable_gate;
		!en_ok |=> (high_gate_out == 3'h0) && (low_gate_out == 3'h0);
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("gate on while disabled");

	property p_mid_low;
		({lvl_sync_reg[0], 1'b0} < {1'b0, lvl_sync_reg[3]}) |=> !midpoint_flag_a_out;
	endproperty
	a_mid_low: assert property (p_mid_low) else $error("midpoint flag high below half");

	property p_rx_fall;
		(sclk_fall && !cs_n_s && !cs_fall) |=> rx_reg[0] == $past(si_s);
	endproperty
	a_rx_fall: assert property (p_rx_fall) else $error("bit not taken on falling edge");

	property p_so_float;
		cs_n_s |=> so_oe_n_out ##1 so_oe_n_out || !cs_n_s;
	endproperty
	a_so_float: assert property (p_so_float) else $error("serial out driven unselected");

	property p_no_shift_idle;
		cs_n_s |=> $stable(rx_reg) && $stable(bit_cnt_reg);
	endproperty
	a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift while idle");

	property p_irq_frame;
		frame_bad |=> irq_out && frame_err_reg;
	endproperty
	a_irq_frame: assert property (p_irq_frame) else $error("framing error lost");

	property p_dead_load;
		(frame_ok && op == `GCI_OP_DEADTIME) |=> dead_reg == $past(rx_reg[DT_W-1:0]);
	endproperty
	a_dead_load: assert property (p_dead_load) else $error("dead time not loaded");

	property p_oc_follow;
		$changed(oc_s) |=> overcurrent_flag_out == $past(oc_s);
	endproperty
	a_oc_follow: assert property (p_oc_follow) else $error("overcurrent flag stale");

	property p_reset_default;
		$rose(rst_n_in) |-> dead_reg == `GCI_DT_RESET && !overlap_en_reg && high_gate_out == 3'h0;
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("setup not default");

	c_dead_cmd: cover property (frame_ok && op == `GCI_OP_DEADTIME);
	c_safe_armed: cover property ($rose(overlap_en_reg));
	c_high_on: cover property ($rose(high_gate_out[0]));
	c_low_after_high: cover property ($fell(high_gate_out[0]) ##[1:300] $rose(low_gate_out[0]));

endmodule

// ===== verif/gci_mcu_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Controller model: serial setup master
// ----------------------------------------------------------------
module gci_mcu_model (
	input wire logic so_in,
	input wire logic so_oe_n_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic si_out
);
	// Link half period; faster than typical, the sampler still copes
	localparam realtime HALF = 40.0;

	// Idle: clock still, select high
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b1;
	end

	// One framed exchange; reply taken just before each falling edge
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx,
			output logic oe_bad);
		rx = 16'h0000;
		oe_bad = 1'b0;
		cs_n_out = 1'b0;
		#60;
		for (int i = 0; i < nbits; i++) begin
			si_out = tx[15 - i];
			sclk_out = 1'b1;
			#HALF;
			rx = {rx[14:0], so_in};
			oe_bad = oe_bad | so_oe_n_in;
			sclk_out = 1'b0;
			#HALF;
		end
		cs_n_out = 1'b1;
		si_out = ~si_out; // Released line does not keep its value
		#60;
	endtask

	// Clock bursts with select high, on command of the bench only
	task automatic stray_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			si_out = ~si_out;
			sclk_out = 1'b1;
			#HALF;
			sclk_out = 1'b0;
			#HALF;
		end
	endtask
endmodule

// ===== verif/gci_top_tb_top.sv
`timescale 1ns/1ps

`define GCI_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected at %0t got %h exp %h", $time, got, exp); end end

module gci_top_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en_a = 1'b1;
	logic en_b = 1'b1;
	logic [2:0] hi_n = 3'h7;
	logic [2:0] lo = 3'h0;
	logic [9:0] src_a = 10'h000;
	logic [9:0] src_b = 10'h000;
	logic [9:0] src_c = 10'h000;
	logic [9:0] sup = 10'h258;
	logic oc = 1'b0;
	logic sclk, cs_n, si;
	logic [2:0] high_gate, low_gate;
	logic mid_a, mid_b, mid_c, oc_flag, irq, so, so_oe_n;
	logic [15:0] rx;
	logic oe_bad;
	int num_errors = 0;
	int n_compared = 0;

	// ----------------------------------------------------------------
	// Clock, design and controller
	// ----------------------------------------------------------------
	always #2.5 clk = ~clk;

	gci_top dut (.ref_clk_in(clk), .rst_n_in(rst_n), .gate_enable_a_in(en_a),
		.gate_enable_b_in(en_b), .ph_a_high_cmd_n_in(hi_n[0]), .ph_b_high_cmd_n_in(hi_n[1]),
		.ph_c_high_cmd_n_in(hi_n[2]), .ph_a_low_cmd_in(lo[0]), .ph_b_low_cmd_in(lo[1]),
		.ph_c_low_cmd_in(lo[2]), .high_source_a_in(src_a), .high_source_b_in(src_b),
		.high_source_c_in(src_c), .load_supply_level_in(sup), .overcurrent_cmp_in(oc),
		.sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .high_gate_out(high_gate),
		.low_gate_out(low_gate), .midpoint_flag_a_out(mid_a), .midpoint_flag_b_out(mid_b),
		.midpoint_flag_c_out(mid_c), .overcurrent_flag_out(oc_flag), .irq_out(irq),
		.so_out(so), .so_oe_n_out(so_oe_n));

	gci_mcu_model mcu (.so_in(so), .so_oe_n_in(so_oe_n), .sclk_out(sclk), .cs_n_out(cs_n),
		.si_out(si));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Each phase, each side: high on exactly three edges after the pin, low on within 25
	task automatic t_gates();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			hi_n <= ~(3'h1 << i);
			cyc(2);
			`GCI_CHK(high_gate, 3'h0)
			cyc(1);
			`GCI_CHK(high_gate, 3'(1 << i))
			@(posedge clk);
			hi_n <= 3'h7;
			lo <= 3'(1 << i);
			cyc(25);
			`GCI_CHK(low_gate, 3'(1 << i))
			`GCI_CHK(high_gate, 3'h0)
			@(posedge clk);
			lo <= 3'h0;
			cyc(25);
		end
		$display("t_gates done");
	endtask

	// Either enable low forces every gate off
	task automatic t_enable();
		@(posedge clk);
		hi_n <= 3'h6;
		lo <= 3'h6;
		cyc(30);
		`GCI_CHK({high_gate, low_gate}, 6'h0e)
		@(posedge clk);
		en_a <= 1'b0;
		cyc(3);
		`GCI_CHK({high_gate, low_gate}, 6'h00)
		@(posedge clk);
		en_a <= 1'b1;
		cyc(30);
		`GCI_CHK({high_gate, low_gate}, 6'h0e)
		@(posedge clk);
		en_b <= 1'b0;
		cyc(3);
		`GCI_CHK({high_gate, low_gate}, 6'h00)
		@(posedge clk);
		hi_n <= 3'h7;
		lo <= 3'h0;
		en_b <= 1'b1;
		cyc(30);
		$display("t_enable done");
	endtask

	// Midpoint flags at and just under half supply; overcurrent follows
	task automatic t_flags();
		@(posedge clk);
		src_a <= 10'h12c;
		src_b <= 10'h12b;
		src_c <= 10'h3ff;
		cyc(6);
		`GCI_CHK({mid_c, mid_b, mid_a}, 3'h5)
		@(posedge clk);
		src_a <= 10'h000;
		src_b <= 10'h12c;
		cyc(6);
		`GCI_CHK({mid_c, mid_b, mid_a}, 3'h6)
		@(posedge clk);
		oc <= 1'b1;
		cyc(6);
		`GCI_CHK({oc_flag, irq}, 2'h3)
		@(posedge clk);
		oc <= 1'b0;
		cyc(6);
		`GCI_CHK(oc_flag, 1'b0)
		$display("t_flags done");
	endtask

	// Serial port: reply, float, dead time write, framing fault, stray clocks
	task automatic t_spi();
		`GCI_CHK(so_oe_n, 1'b1)
		mcu.xfer(16'h3000, 16, rx, oe_bad);
		`GCI_CHK({oe_bad, rx[15:12], rx[7:0]}, 13'h0210)
		`GCI_CHK({so_oe_n, irq}, 2'h2)
		mcu.xfer(16'h1005, 16, rx, oe_bad);
		mcu.xfer(16'h0000, 16, rx, oe_bad);
		`GCI_CHK(rx[7:0], 8'h05)
		mcu.xfer(16'h10ff, 8, rx, oe_bad);
		`GCI_CHK(irq, 1'b1)
		mcu.stray_clocks(16);
		mcu.xfer(16'h3000, 16, rx, oe_bad);
		`GCI_CHK({rx[14], rx[7:0], irq}, 10'h20a)
		$display("t_spi done");
	endtask

	// Dead time setting of five gives seven cycles between high falling and low rising
	task automatic t_dead();
		int n;
		n = 0;
		@(posedge clk);
		hi_n <= 3'h6;
		cyc(30);
		@(posedge clk);
		hi_n <= 3'h7;
		lo <= 3'h1;
		while (high_gate[0] === 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (low_gate[0] !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		`GCI_CHK(n[7:0], 8'h07)
		@(posedge clk);
		lo <= 3'h0;
		cyc(30);
		$display("t_dead done");
	endtask

	// Overlap refused until armed by the keyed command
	task automatic t_safe();
		@(posedge clk);
		hi_n <= 3'h6;
		lo <= 3'h1;
		cyc(10);
		`GCI_CHK({high_gate, low_gate}, 6'h00)
		@(posedge clk);
		hi_n <= 3'h7;
		lo <= 3'h0;
		mcu.xfer(16'h6a5c, 16, rx, oe_bad);
		@(posedge clk);
		hi_n <= 3'h6;
		lo <= 3'h1;
		cyc(10);
		`GCI_CHK({high_gate, low_gate}, 6'h09)
		@(posedge clk);
		hi_n <= 3'h7;
		lo <= 3'h0;
		mcu.xfer(16'h6000, 16, rx, oe_bad);
		`GCI_CHK(rx[15], 1'b1)
		mcu.xfer(16'h0000, 16, rx, oe_bad);
		`GCI_CHK(rx[15], 1'b0)
		$display("t_safe done");
	endtask

	// Reset in mid-run drops a live gate and restores the default setup
	task automatic t_rst2();
		@(posedge clk);
		hi_n <= 3'h6;
		cyc(30);
		`GCI_CHK(high_gate, 3'h1)
		@(posedge clk);
		rst_n <= 1'b0;
		cyc(3);
		`GCI_CHK({high_gate, low_gate, so_oe_n, irq}, 8'h02)
		@(posedge clk);
		hi_n <= 3'h7;
		rst_n <= 1'b1;
		cyc(5);
		mcu.xfer(16'h0000, 16, rx, oe_bad);
		`GCI_CHK({rx[15], rx[7:0]}, 9'h010)
		$display("t_rst2 done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		cyc(19);
		`GCI_CHK({high_gate, low_gate, so_oe_n, so, irq}, 9'h004)
		// Released on the twentieth edge, which still sees reset low
		@(posedge clk);
		rst_n <= 1'b1;
		cyc(5);
		t_gates();
		t_enable();
		t_flags();
		t_spi();
		t_dead();
		t_safe();
		t_rst2();
		test_done();
	end

	// Whole run takes about 16 us; cut a hang well after that
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
endmodule
